// >>> logic/rtc_pkg.sv
// constants, field layouts and BCD helpers shared by the real-time clock files
// assumes a single core clock domain; the 32.768 kHz source arrives as a one-cycle tick
package rtc_pkg;

   // slow oscillator and divider
   localparam int OSC_HZ = 32768;
   localparam int DIV_STAGES = 15;
   localparam int SQ16_BIT = 10;

   // register indices within the block
   localparam logic [3:0] SEC_IDX = 4'h0;
   localparam logic [3:0] MIN_IDX = 4'h1;
   localparam logic [3:0] HOUR_IDX = 4'h2;
   localparam logic [3:0] WDAY_IDX = 4'h3;
   localparam logic [3:0] DATE_IDX = 4'h4;
   localparam logic [3:0] MONTH_IDX = 4'h5;
   localparam logic [3:0] YEAR_IDX = 4'h6;
   localparam logic [3:0] PAGE_IDX = 4'h7;
   localparam logic [3:0] RESET_IDX = 4'h8;

   // page register fields
   localparam int PAGE_BIT = 0;
   localparam int ALM_EN_BIT = 2;
   localparam int TMR_EN_BIT = 3;
   localparam int ADJUST_BIT = 4;
   localparam int INT_EN_BIT = 7;

   // reset register fields
   localparam int ALM_CLR_BIT = 4;
   localparam int TMR_RST_BIT = 5;
   localparam int DIS16_BIT = 6;
   localparam int DIS1_BIT = 7;

   // field masks
   localparam logic [7:0] SEC_MASK = 8'h7f;
   localparam logic [7:0] HOUR_MASK = 8'h3f;
   localparam logic [7:0] WDAY_MASK = 8'h07;
   localparam logic [7:0] DATE_MASK = 8'h3f;
   localparam logic [7:0] MONTH_MASK = 8'h1f;

   // limits and power-on values
   localparam logic [7:0] SEC_LAST = 8'h59;
   localparam logic [7:0] HALF_MIN = 8'h30;
   localparam logic [7:0] HOUR24_LAST = 8'h23;
   localparam logic [4:0] HOUR12_LAST = 5'h11;
   localparam logic [7:0] PM_FLAG = 8'h20;
   localparam logic [7:0] WDAY_LAST = 8'h06;
   localparam logic [7:0] MONTH_LAST = 8'h12;
   localparam logic [7:0] YEAR_LAST = 8'h99;
   localparam logic [7:0] FIRST_ONE = 8'h01;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [1:0] LEAP_YEAR = 2'b00;

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9) begin
         return {v[7:4] + 4'h1, 4'h0};
      end
      return {v[7:4], v[3:0] + 4'h1};
   endfunction

   function automatic logic [7:0] days_in_month(input logic [7:0] mon, input logic [1:0] leap);
      unique case (mon)
         8'h02: return (leap == LEAP_YEAR) ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
         default: return 8'h31;
      endcase
   endfunction

endpackage

// >>> logic/rtc_divider.sv
// fifteen-stage binary divider from the slow-oscillator tick to the 1 Hz carry
// assumes osc_tick is a one-cycle pulse per slow-oscillator period, in core_clk domain
`timescale 1ns/10ps
`default_nettype none
module rtc_divider import rtc_pkg::*; #(
   parameter int STAGES = DIV_STAGES
) (
   // clocking
   input wire logic core_clk,
   input wire logic por,
   input wire logic ce,
   // control
   input wire logic osc_tick,
   input wire logic clear,
   // results
   output logic carry,
   output logic one_hz,
   output logic one_hz_fall,
   output logic sixteen_hz,
   output logic sixteen_hz_fall
);
   logic [STAGES-1:0] count;
   localparam logic [STAGES-1:0] ALL_ONES = '1;
   localparam logic [STAGES-1:0] HALF_WAY = ALL_ONES >> 1;
   localparam logic [SQ16_BIT-1:0] SQ16_ONES = '1;

   // clearing restarts a full second before the next wrap
   always_ff @(posedge core_clk) begin
      if (por || (ce && clear)) begin
         count <= '0;
      end else if (ce && osc_tick) begin
         count <= count + 1'b1;
      end
   end

   // 1 Hz wave is high for the first half second, so the wrap is its rising edge
   assign one_hz = ~count[STAGES-1];
   assign sixteen_hz = ~count[SQ16_BIT];
   assign carry = osc_tick && !clear && (count == ALL_ONES);
   assign one_hz_fall = osc_tick && !clear && (count == HALF_WAY);
   assign sixteen_hz_fall = osc_tick && !clear && !count[SQ16_BIT]
                          && (count[SQ16_BIT-1:0] == SQ16_ONES);
endmodule
`default_nettype wire

// >>> logic/rtc_alarm.sv
// alarm field store with don't-care tracking and the match comparator
// assumes field writes are one-cycle strobes qualified by the alarm page
`timescale 1ns/10ps
`default_nettype none
module rtc_alarm import rtc_pkg::*; (
   // clocking
   input wire logic core_clk,
   input wire logic por,
   input wire logic ce,
   // control
   input wire logic clear,
   input wire logic wr_min,
   input wire logic wr_hour,
   input wire logic wr_wday,
   input wire logic wr_date,
   input wire logic [7:0] wr_data,
   // current time
   input wire logic [7:0] cur_min,
   input wire logic [7:0] cur_hour,
   input wire logic [7:0] cur_wday,
   input wire logic [7:0] cur_date,
   // results
   output logic [7:0] alm_min,
   output logic [7:0] alm_hour,
   output logic [7:0] alm_wday,
   output logic [7:0] alm_date,
   output logic match
);
   logic [3:0] armed;

   always_ff @(posedge core_clk) begin
      if (por || (ce && clear)) begin
         armed <= 4'h0;
      end else if (ce) begin
         armed <= armed | {wr_date, wr_wday, wr_hour, wr_min};
      end
   end

   always_ff @(posedge core_clk) begin
      if (por || (ce && clear)) begin
         alm_min <= ZERO8;
         alm_hour <= ZERO8;
         alm_wday <= ZERO8;
         alm_date <= ZERO8;
      end else if (ce) begin
         if (wr_min) alm_min <= wr_data & SEC_MASK;
         if (wr_hour) alm_hour <= wr_data & HOUR_MASK;
         if (wr_wday) alm_wday <= wr_data & WDAY_MASK;
         if (wr_date) alm_date <= wr_data & DATE_MASK;
      end
   end

   // unwritten fields always count as matching
   assign match = (!armed[0] || alm_min == cur_min) && (!armed[1] || alm_hour == cur_hour)
               && (!armed[2] || alm_wday == cur_wday) && (!armed[3] || alm_date == cur_date);
endmodule
`default_nettype wire

// >>> logic/rtc_timekeeping_alarm.sv
// calendar real-time clock: carry hold, BCD calendar, alarm pin and interrupt flag
// assumes host register writes and reads arrive as plain strobes in the core_clk domain;
// por initialises the clock state, rst only the interrupt enable
`timescale 1ns/10ps
`default_nettype none
module rtc_timekeeping_alarm import rtc_pkg::*; #(
   parameter int STAGES = DIV_STAGES
) (
   // clocking and resets
   input wire logic core_clk,
   input wire logic rst,
   input wire logic por,
   input wire logic ce,
   // slow oscillator tick
   input wire logic osc_tick,
   // register write port
   input wire logic wr_en,
   input wire logic [3:0] wr_addr,
   input wire logic [7:0] wr_data,
   // register read port
   input wire logic [3:0] rd_addr,
   output logic [7:0] rd_data,
   // interrupt
   input wire logic irq_clear,
   output logic rtc_interrupt,
   output logic rtc_irq_flag,
   // alarm output, active low on a match
   output logic alarm_pin
);
   // time state
   logic [7:0] sec, min, hour, wday, date, month, year;
   logic [1:0] leap_state;
   logic hour_24;
   // control state
   logic page, alarm_enable, timer_carry_enable, int_enable;
   logic one_hz_disable, sixteen_hz_disable;
   logic carry_hold;
   // next values
   logic [7:0] next_sec, next_min, next_hour, next_wday, next_date, next_month, next_year;
   logic [1:0] next_leap;
   logic step_min, step_hour, step_day, step_month;
   // events and decode
   logic div_carry, one_hz, one_hz_fall, sixteen_hz, sixteen_hz_fall;
   logic apply_carry, adjust_req, timer_reset, alarm_clear;
   logic wr_page0, wr_page1, wr_page_reg, wr_reset_reg;
   logic [7:0] alm_min, alm_hour, alm_wday, alm_date;
   logic alarm_match, match_seen, alarm_hit, irq_event, mode_1hz, mode_16hz;

   assign wr_page_reg = wr_en && (wr_addr == PAGE_IDX);
   assign wr_reset_reg = wr_en && (wr_addr == RESET_IDX);
   assign wr_page0 = wr_en && !page;
   assign wr_page1 = wr_en && page;
   assign adjust_req = wr_page_reg && wr_data[ADJUST_BIT];
   assign timer_reset = wr_reset_reg && wr_data[TMR_RST_BIT];
   assign alarm_clear = wr_reset_reg && wr_data[ALM_CLR_BIT];

   rtc_divider #(
      .STAGES(STAGES)
   ) u_divider (
      .core_clk(core_clk),
      .por(por),
      .ce(ce),
      .osc_tick(osc_tick),
      .clear(timer_reset),
      .carry(div_carry),
      .one_hz(one_hz),
      .one_hz_fall(one_hz_fall),
      .sixteen_hz(sixteen_hz),
      .sixteen_hz_fall(sixteen_hz_fall)
   );

   rtc_alarm u_alarm (
      .core_clk(core_clk),
      .por(por),
      .ce(ce),
      .clear(alarm_clear),
      .wr_min(wr_page1 && wr_addr == MIN_IDX),
      .wr_hour(wr_page1 && wr_addr == HOUR_IDX),
      .wr_wday(wr_page1 && wr_addr == WDAY_IDX),
      .wr_date(wr_page1 && wr_addr == DATE_IDX),
      .wr_data(wr_data),
      .cur_min(min),
      .cur_hour(hour),
      .cur_wday(wday),
      .cur_date(date),
      .alm_min(alm_min),
      .alm_hour(alm_hour),
      .alm_wday(alm_wday),
      .alm_date(alm_date),
      .match(alarm_match)
   );

   // carries pass only while enabled; a held carry is delivered in the first enabled cycle, merged with any fresh carry there
   assign apply_carry = timer_carry_enable && (div_carry || carry_hold);

   always_ff @(posedge core_clk) begin
      if (por) begin
         carry_hold <= 1'b0;
      end else if (ce) begin
         if (div_carry && !timer_carry_enable) begin
            carry_hold <= 1'b1;
         end else if (apply_carry) begin
            carry_hold <= 1'b0;
         end
      end
   end

   // control bits of the page and reset registers survive system reset, except int_enable, which rst clears
   always_ff @(posedge core_clk) begin
      if (por) begin
         page <= 1'b0;
         alarm_enable <= 1'b0;
         timer_carry_enable <= 1'b1;
         one_hz_disable <= 1'b1;
         sixteen_hz_disable <= 1'b1;
      end else if (ce) begin
         if (wr_page_reg) begin
            page <= wr_data[PAGE_BIT];
            alarm_enable <= wr_data[ALM_EN_BIT];
            timer_carry_enable <= wr_data[TMR_EN_BIT];
         end
         if (wr_reset_reg) begin
            one_hz_disable <= wr_data[DIS1_BIT];
            sixteen_hz_disable <= wr_data[DIS16_BIT];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst || por) begin
         int_enable <= 1'b0;
      end else if (ce && wr_page_reg) begin
         int_enable <= wr_data[INT_EN_BIT];
      end
   end

   // calendar cascade; adjust starts at the minutes and takes the place of a carry
   always_comb begin
      next_sec = sec;
      next_min = min;
      next_hour = hour;
      next_wday = wday;
      next_date = date;
      next_month = month;
      next_year = year;
      next_leap = leap_state;
      step_min = 1'b0;
      step_hour = 1'b0;
      step_day = 1'b0;
      step_month = 1'b0;
      if (adjust_req) begin
         next_sec = ZERO8;
         step_min = (sec >= HALF_MIN);
      end else if (apply_carry) begin
         if (sec == SEC_LAST) begin
            next_sec = ZERO8;
            step_min = 1'b1;
         end else begin
            next_sec = bcd_inc(sec);
         end
      end
      if (step_min) begin
         if (min == SEC_LAST) begin
            next_min = ZERO8;
            step_hour = 1'b1;
         end else begin
            next_min = bcd_inc(min);
         end
      end
      if (step_hour) begin
         if (hour_24) begin
            step_day = (hour == HOUR24_LAST);
            next_hour = step_day ? ZERO8 : bcd_inc(hour);
         end else if (hour[4:0] == HOUR12_LAST) begin
            // 11 o'clock rolls to 0 with the PM flag toggled; the day ends after 11 PM
            step_day = hour[5];
            next_hour = hour[5] ? ZERO8 : PM_FLAG;
         end else begin
            next_hour = {hour[7:5], 5'(bcd_inc({3'b000, hour[4:0]}))};
         end
      end
      if (step_day) begin
         next_wday = (wday == WDAY_LAST) ? ZERO8 : bcd_inc(wday);
         if (date == days_in_month(month, leap_state)) begin
            next_date = FIRST_ONE;
            step_month = 1'b1;
         end else begin
            next_date = bcd_inc(date);
         end
      end
      if (step_month) begin
         if (month == MONTH_LAST) begin
            next_month = FIRST_ONE;
            next_year = (year == YEAR_LAST) ? ZERO8 : bcd_inc(year);
            next_leap = leap_state + 2'b01;
         end else begin
            next_month = bcd_inc(month);
         end
      end
   end

   // time registers: host writes override the carry for the field written
   always_ff @(posedge core_clk) begin
      if (por) begin
         sec <= ZERO8;
         min <= ZERO8;
         hour <= ZERO8;
         wday <= ZERO8;
         date <= FIRST_ONE;
         month <= FIRST_ONE;
         year <= ZERO8;
         leap_state <= LEAP_YEAR;
         hour_24 <= 1'b1;
      end else if (ce) begin
         sec <= next_sec;
         min <= next_min;
         hour <= next_hour;
         wday <= next_wday;
         date <= next_date;
         month <= next_month;
         year <= next_year;
         leap_state <= next_leap;
         if (wr_page0) begin
            unique case (wr_addr)
               SEC_IDX: sec <= wr_data & SEC_MASK;
               MIN_IDX: min <= wr_data & SEC_MASK;
               HOUR_IDX: hour <= wr_data & HOUR_MASK;
               WDAY_IDX: wday <= wr_data & WDAY_MASK;
               DATE_IDX: date <= wr_data & DATE_MASK;
               MONTH_IDX: month <= wr_data & MONTH_MASK;
               YEAR_IDX: year <= wr_data;
               default: ;
            endcase
         end
         if (wr_page1 && wr_addr == MONTH_IDX) hour_24 <= wr_data[0];
         if (wr_page1 && wr_addr == YEAR_IDX) leap_state <= wr_data[1:0];
      end
   end

   // alarm pin source selection and interrupt events
   assign mode_1hz = !alarm_enable && !one_hz_disable && sixteen_hz_disable;
   assign mode_16hz = !alarm_enable && one_hz_disable && !sixteen_hz_disable;
   assign alarm_hit = alarm_enable && alarm_match && !match_seen;
   assign irq_event = alarm_hit || (mode_1hz && one_hz_fall)
                   || (mode_16hz && sixteen_hz_fall);

   always_ff @(posedge core_clk) begin
      if (por) begin
         match_seen <= 1'b0;
      end else if (ce) begin
         match_seen <= alarm_enable && alarm_match;
      end
   end

   always_ff @(posedge core_clk) begin
      if (por) begin
         alarm_pin <= 1'b1;
      end else if (ce) begin
         if (alarm_enable) begin
            alarm_pin <= !alarm_match;
         end else if (mode_1hz) begin
            alarm_pin <= one_hz;
         end else if (mode_16hz) begin
            alarm_pin <= sixteen_hz;
         end else begin
            alarm_pin <= 1'b1;
         end
      end
   end

   // the pending flag is not touched by rst so software must clear it after reset
   always_ff @(posedge core_clk) begin
      if (por) begin
         rtc_irq_flag <= 1'b0;
         rtc_interrupt <= 1'b0;
      end else if (ce) begin
         rtc_interrupt <= irq_event && int_enable;
         if (irq_event && int_enable) begin
            rtc_irq_flag <= 1'b1;
         end else if (irq_clear) begin
            rtc_irq_flag <= 1'b0;
         end
      end
   end

   // read port: one cycle latency, page selects time or alarm view
   always_ff @(posedge core_clk) begin
      if (por) begin
         rd_data <= ZERO8;
      end else if (ce) begin
         unique case (rd_addr)
            SEC_IDX: rd_data <= page ? ZERO8 : sec;
            MIN_IDX: rd_data <= page ? alm_min : min;
            HOUR_IDX: rd_data <= page ? alm_hour : hour;
            WDAY_IDX: rd_data <= page ? alm_wday : wday;
            DATE_IDX: rd_data <= page ? alm_date : date;
            MONTH_IDX: rd_data <= page ? {7'b000_0000, hour_24} : month;
            YEAR_IDX: rd_data <= page ? {6'b00_0000, leap_state} : year;
            PAGE_IDX: rd_data <= {int_enable, 3'b000, timer_carry_enable, alarm_enable,
                                  1'b0, page};
            default: rd_data <= ZERO8;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> sim/rtc_timekeeping_alarm_sva.sv
// checker for the real-time clock top: interrupt pulse, pending flag, alarm pin, read port
// assumes ce is held high while checking; bound to every instance of the top module
`timescale 1ns/10ps
`default_nettype none
module rtc_timekeeping_alarm_sva import rtc_pkg::*; #(
   parameter int STAGES = DIV_STAGES
) (
   // clocking and resets
   input wire logic core_clk,
   input wire logic rst,
   input wire logic por,
   input wire logic ce,
   // stimulus
   input wire logic osc_tick,
   input wire logic wr_en,
   input wire logic [3:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [3:0] rd_addr,
   input wire logic irq_clear,
   // results
   input wire logic [7:0] rd_data,
   input wire logic rtc_interrupt,
   input wire logic rtc_irq_flag,
   input wire logic alarm_pin
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (por);

   a_irq_single: assert property (rtc_interrupt |=> !rtc_interrupt [*3])
      else $error("interrupt pulse not single");
   a_irq_sets_flag: assert property (rtc_interrupt |-> ##[0:1] rtc_irq_flag)
      else $error("interrupt without pending flag");
   a_flag_cause: assert property ($rose(rtc_irq_flag) |-> rtc_interrupt || $past(rtc_interrupt))
      else $error("flag set without interrupt");
   a_flag_held: assert property (rtc_irq_flag && !irq_clear |=> rtc_irq_flag)
      else $error("flag dropped without clear");
   a_flag_clear: assert property ((irq_clear && !rtc_interrupt) [*3] |-> !rtc_irq_flag)
      else $error("flag not cleared");
   a_irq_pin_low: assert property (rtc_interrupt |-> ##[0:2] !alarm_pin)
      else $error("interrupt without low alarm pin");
   // no disable here: the reset itself is the antecedent
   a_por_state: assert property (disable iff (1'b0)
      por |=> alarm_pin && !rtc_interrupt && !rtc_irq_flag && rd_data == 8'h00)
      else $error("power-on state wrong");
   // a held carry lands one edge after the enabling write, so that write counts as a cause
   a_rd_steady: assert property ((!wr_en ##1 (!wr_en && !osc_tick && !rst)) ##1 $stable(rd_addr)
      |=> $stable(rd_data))
      else $error("read data changed without cause");

   c_irq: cover property (rtc_interrupt);
   c_pin_fall: cover property ($fell(alarm_pin));
   c_flag: cover property ($rose(rtc_irq_flag));
endmodule
bind rtc_timekeeping_alarm rtc_timekeeping_alarm_sva #(.STAGES(STAGES)) i_sva (
   .core_clk(core_clk), .rst(rst), .por(por), .ce(ce), .osc_tick(osc_tick), .wr_en(wr_en),
   .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .irq_clear(irq_clear),
   .rd_data(rd_data), .rtc_interrupt(rtc_interrupt), .rtc_irq_flag(rtc_irq_flag),
   .alarm_pin(alarm_pin));
`default_nettype wire

// >>> sim/rtc_timekeeping_alarm_tb.sv
// self-checking bench for the real-time clock top, driven through its plain register strobes
// assumes a shortened divider (STAGES 12) and one oscillator tick every two core cycles
`timescale 1ns/10ps
`default_nettype none
module rtc_timekeeping_alarm_tb;
   import rtc_pkg::*;
   localparam int ST = 12;
   localparam int N = 1 << ST;
   logic core_clk, rst, por, ce, osc_tick, wr_en, irq_clear;
   logic [3:0] wr_addr, rd_addr;
   logic [7:0] wr_data, rd_data;
   logic rtc_interrupt, rtc_irq_flag, alarm_pin;
   logic pin_q = 1'b1;
   int fails, n_compared, base_falls, base_irqs;
   int falls = 0;
   int irqs = 0;
   logic [7:0] modes [2] = '{8'h60, 8'hA0};
   int exp_falls [2];

   rtc_timekeeping_alarm #(.STAGES(ST)) i_dut (
      .core_clk(core_clk), .rst(rst), .por(por), .ce(ce), .osc_tick(osc_tick),
      .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
      .rd_data(rd_data), .irq_clear(irq_clear), .rtc_interrupt(rtc_interrupt),
      .rtc_irq_flag(rtc_irq_flag), .alarm_pin(alarm_pin));

   always #5 core_clk = ~core_clk;

   // edge and pulse counters for the square-wave modes; falling edge so the
   // registered outputs have settled, and a one-cycle pulse is seen exactly once
   always @(negedge core_clk) begin
      pin_q <= alarm_pin;
      if (pin_q === 1'b1 && alarm_pin === 1'b0) falls <= falls + 1;
      if (rtc_interrupt === 1'b1) irqs <= irqs + 1;
   end

   task automatic cmp(input string nm, input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge core_clk);
      wr_en = 1'b1;
      wr_addr = a;
      wr_data = d;
      @(negedge core_clk);
      wr_en = 1'b0;
   endtask
   task automatic chk(input logic [3:0] a, input logic [7:0] exp, input string nm);
      @(negedge core_clk);
      rd_addr = a;
      @(negedge core_clk);
      cmp(nm, rd_data, exp);
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(negedge core_clk);
         osc_tick = 1'b1;
         @(negedge core_clk);
         osc_tick = 1'b0;
      end
   endtask
   // held for several cycles so a pending set cannot hide the clear
   task automatic clr_irq();
      @(negedge core_clk);
      irq_clear = 1'b1;
      repeat (4) @(negedge core_clk);
      irq_clear = 1'b0;
   endtask
   task automatic pins(input logic pin, input logic flag);
      repeat (3) @(negedge core_clk);
      cmp("alarm_pin", {7'h0, alarm_pin}, {7'h0, pin});
      cmp("rtc_irq_flag", {7'h0, rtc_irq_flag}, {7'h0, flag});
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge core_clk);
      fails++;
      report_and_stop();
   end

   initial begin
      core_clk = 1'b0; rst = 1'b1; por = 1'b1; ce = 1'b1; osc_tick = 1'b0; wr_en = 1'b0;
      wr_addr = 4'h0; wr_data = 8'h00; rd_addr = 4'h0; irq_clear = 1'b0;
      fails = 0; n_compared = 0;
      repeat (16) @(negedge core_clk);
      rst = 1'b0;
      por = 1'b0;
      chk(DATE_IDX, 8'h01, "date");
      wr(SEC_IDX, 8'h45);
      @(negedge core_clk);
      rst = 1'b1;
      repeat (2) @(negedge core_clk);
      rst = 1'b0;
      chk(SEC_IDX, 8'h45, "sec after rst");
      $display("test reset done");
      // calendar rollover into a leap February 29th
      wr(PAGE_IDX, 8'h09);
      wr(YEAR_IDX, 8'h00);
      wr(MONTH_IDX, 8'h01);
      wr(PAGE_IDX, 8'h08);
      wr(SEC_IDX, 8'h58);
      wr(MIN_IDX, 8'h59);
      wr(HOUR_IDX, 8'h23);
      wr(WDAY_IDX, 8'h06);
      wr(DATE_IDX, 8'h28);
      wr(MONTH_IDX, 8'h02);
      wr(RESET_IDX, 8'hE0);
      ticks(N - 1);
      chk(SEC_IDX, 8'h58, "sec before carry");
      ticks(1);
      chk(SEC_IDX, 8'h59, "sec at carry");
      ticks(N);
      chk(SEC_IDX, 8'h00, "sec wrap");
      chk(MIN_IDX, 8'h00, "min wrap");
      chk(HOUR_IDX, 8'h00, "hour wrap");
      chk(WDAY_IDX, 8'h00, "wday wrap");
      chk(DATE_IDX, 8'h29, "leap date");
      chk(MONTH_IDX, 8'h02, "month");
      $display("test calendar done");
      wr(PAGE_IDX, 8'h00);
      wr(RESET_IDX, 8'hE0);
      ticks(N);
      chk(SEC_IDX, 8'h00, "sec blocked");
      wr(PAGE_IDX, 8'h08);
      chk(SEC_IDX, 8'h01, "held carry");
      wr(PAGE_IDX, 8'h00);
      wr(RESET_IDX, 8'hE0);
      ticks(2 * N);
      wr(PAGE_IDX, 8'h08);
      chk(SEC_IDX, 8'h02, "one carry kept");
      $display("test carry hold done");
      wr(SEC_IDX, 8'h29);
      wr(PAGE_IDX, 8'h18);
      chk(SEC_IDX, 8'h00, "adjust low sec");
      chk(MIN_IDX, 8'h00, "adjust low min");
      wr(SEC_IDX, 8'h30);
      wr(PAGE_IDX, 8'h18);
      chk(SEC_IDX, 8'h00, "adjust high sec");
      chk(MIN_IDX, 8'h01, "adjust high min");
      // 12-hour mode: 11 AM rolls to 0 PM, 11 PM rolls to the next day
      wr(PAGE_IDX, 8'h09);
      wr(MONTH_IDX, 8'h00);
      wr(PAGE_IDX, 8'h08);
      wr(HOUR_IDX, 8'h11);
      wr(MIN_IDX, 8'h59);
      wr(SEC_IDX, 8'h30);
      wr(PAGE_IDX, 8'h18);
      chk(HOUR_IDX, 8'h20, "12h noon");
      wr(HOUR_IDX, 8'h31);
      wr(MIN_IDX, 8'h59);
      wr(SEC_IDX, 8'h30);
      wr(PAGE_IDX, 8'h18);
      chk(HOUR_IDX, 8'h00, "12h midnight");
      chk(WDAY_IDX, 8'h01, "wday step");
      chk(DATE_IDX, 8'h01, "leap month end");
      chk(MONTH_IDX, 8'h03, "month step");
      $display("test adjust done");
      wr(PAGE_IDX, 8'h09);
      wr(RESET_IDX, 8'hD0);
      wr(MIN_IDX, 8'h05);
      wr(PAGE_IDX, 8'h8C);
      pins(1'b1, 1'b0);
      wr(MIN_IDX, 8'h05);
      pins(1'b0, 1'b1);
      clr_irq();
      pins(1'b0, 1'b0);
      wr(MIN_IDX, 8'h06);
      pins(1'b1, 1'b0);
      wr(PAGE_IDX, 8'h89);
      wr(RESET_IDX, 8'hD0);
      wr(PAGE_IDX, 8'h8C);
      pins(1'b0, 1'b1);
      $display("test alarm done");
      // 1 Hz then 16 Hz, each from a freshly cleared divider
      exp_falls[0] = (2 * N) >> ST;
      exp_falls[1] = (2 * N) >> (SQ16_BIT + 1);
      wr(PAGE_IDX, 8'h88);
      for (int m = 0; m < 2; m++) begin
         wr(RESET_IDX, modes[m]);
         repeat (3) @(negedge core_clk);
         base_falls = falls;
         base_irqs = irqs;
         ticks(2 * N);
         repeat (3) @(negedge core_clk);
         if (m == 0) begin
            // the last tick was a carry: pin just rose, time is safe to read twice
            cmp("pin after carry", {7'h0, alarm_pin}, 8'h01);
            chk(SEC_IDX, 8'h02, "sec after pin rise");
            chk(SEC_IDX, 8'h02, "sec reread");
         end
         cmp("wave falls", 8'(falls - base_falls), 8'(exp_falls[m]));
         cmp("wave irqs", 8'(irqs - base_irqs), 8'(exp_falls[m]));
      end
      $display("test waves done");
      report_and_stop();
   end
endmodule
`default_nettype wire
